// ==== ext_flash_setup_cmd_handler.sv ====
// Command handler that sets up external flash access and loads the driver
//
// Contract
// R1 - Host opens with command 36h, length 07h
// R2 - Clock code 00h-03h, supply code 00h-01h
// R3 - Only command start byte opens packet
// R4 - Missing end byte gives packet error
// R5 - Checksum mismatch gives checksum error
// R6 - Bad or wrong length gives packet error
// R7 - On error abandon, await next command
// R8 - Lifecycle forbids command: acceptance error
// R9 - No reset since encrypted write: acceptance error
// R10 - Lowest authentication level: secure error
// R11 - Bad clock or supply code: parameter error
// R12 - Driver length zero or over 37000h: error
// R13 - Checks pass: set up interface, send OK
// R14 - Host sends 4-1024 byte payloads, length N+1
// R15 - Data packet opens only on data start
// R16 - Data framing, length, checksum errors reported
// R17 - Wrong response code in data: packet error
// R18 - Payload total over driver length: parameter error
// R19 - Store payload, then OK, host waits
// R20 - Final packet stored, then call initialization
// R21 - Init result selects error or OK status
// R22 - Error packet B6h, filled details, priority order
// R23 - Final when total equals driver length
// R24 - Payloads stored contiguously from driver base
`timescale 1ns/1ps
module ext_flash_setup_cmd_handler
    import ext_flash_setup_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic lifecycle_allows_i,
    input wire logic reset_since_enc_write_i,
    input wire logic auth_lowest_i,
    output logic flash_if_setup_o,
    output logic [7:0] octal_clock_code_o,
    output logic [7:0] supply_code_o,
    output logic [31:0] driver_length_o,
    output logic init_req_o,
    input wire logic init_done_i,
    input wire logic [31:0] init_result_i,
    input wire logic [DRV_AW-1:0] drv_rd_addr_i,
    output logic [31:0] drv_rd_data_o
);
    function automatic logic [7:0] status_byte(input logic [3:0] idx,
                                               input logic [7:0] res,
                                               input logic [7:0] sts);
        logic [7:0] sum;
        sum = STATUS_LEN_HIGH + STATUS_LEN_LOW + res + sts
            + {FILL_BYTE[4:0], 3'b000};
        case (idx)
            4'h0: status_byte = DATA_START_BYTE;
            4'h1: status_byte = STATUS_LEN_HIGH;
            4'h2: status_byte = STATUS_LEN_LOW;
            4'h3: status_byte = res;
            4'h4: status_byte = sts;
            4'hD: status_byte = 8'h00 - sum;
            4'hE: status_byte = PKT_END_BYTE;
            default: status_byte = FILL_BYTE;
        endcase
    endfunction : status_byte

    state_e state_r, state_nxt;
    logic data_kind_r, data_kind_nxt;
    logic [15:0] len_r, len_nxt;
    logic [10:0] cnt_r, cnt_nxt;
    logic [7:0] sum_r, sum_nxt;
    logic sum_ok_r, sum_ok_nxt;
    logic end_ok_r, end_ok_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] ock_r, ock_nxt;
    logic [7:0] vcc_r, vcc_nxt;
    logic [31:0] lop_r, lop_nxt;
    logic [7:0] res_in_r, res_in_nxt;
    logic [31:0] done_r, done_nxt;
    logic [31:0] word_r, word_nxt;
    logic [7:0] res_out_r, res_out_nxt;
    logic [7:0] sts_r, sts_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [7:0] tx_data_r, tx_data_nxt;
    logic setup_r, setup_nxt;
    logic init_r, init_nxt;
    logic [7:0] ock_out_r, ock_out_nxt;
    logic [7:0] vcc_out_r, vcc_out_nxt;
    logic wr_en;
    logic [7:0] hunt_byte;
    logic [31:0] wr_off;
    logic [31:0] pkt_bytes;
    logic [31:0] total;

    assign tx_valid_o = (state_r == ST_SEND);
    assign tx_data_o = tx_data_r;
    assign flash_if_setup_o = setup_r;
    assign init_req_o = init_r;
    assign octal_clock_code_o = ock_out_r;
    assign supply_code_o = vcc_out_r;
    assign driver_length_o = lop_r;
    assign wr_off = done_r + 32'(cnt_r) - 32'h0000_0001;
    assign hunt_byte = data_kind_r ? DATA_START_BYTE : CMD_START_BYTE;
    assign pkt_bytes = {16'h0000, len_r} - 32'h0000_0001;
    assign total = done_r + pkt_bytes;

    always_comb begin
        state_nxt = state_r;
        data_kind_nxt = data_kind_r;
        len_nxt = len_r;
        cnt_nxt = cnt_r;
        sum_nxt = sum_r;
        sum_ok_nxt = sum_ok_r;
        end_ok_nxt = end_ok_r;
        cmd_nxt = cmd_r;
        ock_nxt = ock_r;
        vcc_nxt = vcc_r;
        lop_nxt = lop_r;
        res_in_nxt = res_in_r;
        done_nxt = done_r;
        word_nxt = word_r;
        res_out_nxt = res_out_r;
        sts_nxt = sts_r;
        idx_nxt = idx_r;
        tx_data_nxt = tx_data_r;
        setup_nxt = 1'b0;
        init_nxt = 1'b0;
        ock_out_nxt = ock_out_r;
        vcc_out_nxt = vcc_out_r;
        wr_en = 1'b0;
        case (state_r)
            ST_HUNT: begin
                if (rx_valid_i && rx_data_i == hunt_byte) begin // R3 R15
                    state_nxt = ST_LEN_HIGH;
                end
            end
            ST_LEN_HIGH: begin
                if (rx_valid_i) begin
                    len_nxt = {rx_data_i, 8'h00};
                    sum_nxt = rx_data_i;
                    state_nxt = ST_LEN_LOW;
                end
            end
            ST_LEN_LOW: begin
                if (rx_valid_i) begin
                    len_nxt = {len_r[15:8], rx_data_i};
                    sum_nxt = sum_r + rx_data_i;
                    cnt_nxt = 11'h000;
                    if (len_nxt < PKT_LEN_MIN
                        || len_nxt > PKT_LEN_MAX) begin // R6 R16
                        res_out_nxt = RESP_ERR;
                        sts_nxt = STS_PACKET_ERR;
                        data_kind_nxt = 1'b0; // R7
                        tx_data_nxt = DATA_START_BYTE;
                        state_nxt = ST_SEND;
                    end else begin
                        state_nxt = ST_BODY;
                    end
                end
            end
            ST_BODY: begin
                if (rx_valid_i) begin
                    sum_nxt = sum_r + rx_data_i;
                    cnt_nxt = cnt_r + 11'h001;
                    if (!data_kind_r) begin
                        case (cnt_r)
                            11'd0: cmd_nxt = rx_data_i;
                            11'd1: ock_nxt = rx_data_i;
                            11'd2: vcc_nxt = rx_data_i;
                            default: lop_nxt = {lop_r[23:0], rx_data_i};
                        endcase
                    end else if (cnt_r == 11'd0) begin
                        res_in_nxt = rx_data_i;
                    end else begin
                        word_nxt = {rx_data_i, word_r[31:8]}; // R24
                        wr_en = (wr_off[1:0] == 2'd3) && (wr_off < lop_r); // R18
                    end
                    if ({5'h00, cnt_nxt} == len_r) begin
                        state_nxt = ST_SUM;
                    end
                end
            end
            ST_SUM: begin
                if (rx_valid_i) begin
                    sum_ok_nxt = ((sum_r + rx_data_i) == 8'h00); // R5
                    state_nxt = ST_END;
                end
            end
            ST_END: begin
                if (rx_valid_i) begin
                    end_ok_nxt = (rx_data_i == PKT_END_BYTE); // R4
                    state_nxt = ST_EVAL;
                end
            end
            ST_EVAL: begin
                res_out_nxt = RESP_ERR; // R22
                data_kind_nxt = 1'b0; // R7
                state_nxt = ST_SEND;
                if (!end_ok_r) begin // R22
                    sts_nxt = STS_PACKET_ERR; // R4 R16
                end else if (!sum_ok_r) begin
                    sts_nxt = STS_CHECKSUM_ERR; // R5 R16
                end else if (!data_kind_r) begin
                    if (len_r != CMD_LEN || cmd_r != CMD_CODE) begin // R1 R6
                        sts_nxt = STS_PACKET_ERR;
                    end else if (!lifecycle_allows_i) begin
                        sts_nxt = STS_ACCEPT_ERR; // R8
                    end else if (!reset_since_enc_write_i) begin
                        sts_nxt = STS_ACCEPT_ERR; // R9
                    end else if (auth_lowest_i) begin
                        sts_nxt = STS_SECURE_ERR; // R10
                    end else if (ock_r > OCK_MAX || vcc_r > SUPPLY_MAX) begin
                        sts_nxt = STS_PARAM_ERR; // R2 R11
                    end else if (lop_r == 32'h0 || lop_r > DRV_LEN_MAX) begin
                        sts_nxt = STS_PARAM_ERR; // R12
                    end else begin
                        setup_nxt = 1'b1; // R13
                        ock_out_nxt = ock_r;
                        vcc_out_nxt = vcc_r;
                        res_out_nxt = RESP_OK;
                        sts_nxt = STS_OK;
                        done_nxt = 32'h0;
                        data_kind_nxt = 1'b1;
                    end
                end else if (len_r < DATA_LEN_MIN
                             || pkt_bytes[1:0] != 2'b00) begin // R14 R16
                    sts_nxt = STS_PACKET_ERR;
                end else if (res_in_r != RESP_OK) begin
                    sts_nxt = STS_PACKET_ERR; // R17
                end else if (total > lop_r) begin
                    sts_nxt = STS_PARAM_ERR; // R18
                end else begin
                    done_nxt = total;
                    res_out_nxt = RESP_OK;
                    sts_nxt = STS_OK;
                    if (total == lop_r) begin // R23
                        init_nxt = 1'b1; // R20
                        state_nxt = ST_INIT_WAIT;
                    end else begin
                        data_kind_nxt = 1'b1; // R19
                    end
                end
                tx_data_nxt = status_byte(4'h0, res_out_nxt, sts_nxt);
            end
            ST_INIT_WAIT: begin
                if (init_done_i) begin
                    if (init_result_i == INIT_OK) begin // R21
                        res_out_nxt = RESP_OK;
                        sts_nxt = STS_OK;
                    end else begin
                        res_out_nxt = RESP_ERR;
                        sts_nxt = STS_FLASH_INIT_ERR;
                    end
                    data_kind_nxt = 1'b0;
                    tx_data_nxt = status_byte(4'h0, res_out_nxt, sts_nxt);
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_ready_i) begin
                    idx_nxt = idx_r + 4'h1;
                    tx_data_nxt = status_byte(idx_nxt, res_out_r, sts_r);
                    if (idx_r == STATUS_LAST_IDX) begin
                        idx_nxt = 4'h0;
                        state_nxt = ST_HUNT;
                    end
                end
            end
            default: begin
                state_nxt = ST_HUNT;
                data_kind_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_r <= ST_HUNT;
            data_kind_r <= 1'b0;
            len_r <= 16'h0000;
            cnt_r <= 11'h000;
            sum_r <= 8'h00;
            sum_ok_r <= 1'b0;
            end_ok_r <= 1'b0;
            cmd_r <= 8'h00;
            ock_r <= 8'h00;
            vcc_r <= 8'h00;
            lop_r <= 32'h0000_0000;
            res_in_r <= 8'h00;
            done_r <= 32'h0000_0000;
            word_r <= 32'h0000_0000;
            res_out_r <= 8'h00;
            sts_r <= 8'h00;
            idx_r <= 4'h0;
            tx_data_r <= 8'h00;
            setup_r <= 1'b0;
            init_r <= 1'b0;
            ock_out_r <= 8'h00;
            vcc_out_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            data_kind_r <= data_kind_nxt;
            len_r <= len_nxt;
            cnt_r <= cnt_nxt;
            sum_r <= sum_nxt;
            sum_ok_r <= sum_ok_nxt;
            end_ok_r <= end_ok_nxt;
            cmd_r <= cmd_nxt;
            ock_r <= ock_nxt;
            vcc_r <= vcc_nxt;
            lop_r <= lop_nxt;
            res_in_r <= res_in_nxt;
            done_r <= done_nxt;
            word_r <= word_nxt;
            res_out_r <= res_out_nxt;
            sts_r <= sts_nxt;
            idx_r <= idx_nxt;
            tx_data_r <= tx_data_nxt;
            setup_r <= setup_nxt;
            init_r <= init_nxt;
            ock_out_r <= ock_out_nxt;
            vcc_out_r <= vcc_out_nxt;
        end
    end

    drv_ram u_drv_ram (
        .mclk_i(mclk_i),
        .wr_en_i(wr_en),
        .wr_addr_i(DRV_BASE_WORD + wr_off[17:2]),
        .wr_data_i(word_nxt),
        .rd_addr_i(drv_rd_addr_i),
        .rd_data_o(drv_rd_data_o)
    );
endmodule : ext_flash_setup_cmd_handler

// ==== ext_flash_setup_pkg.sv ====
// Constants and types shared by the external flash setup command handler
package ext_flash_setup_pkg;
    localparam logic [7:0] CMD_START_BYTE = 8'h01;
    localparam logic [7:0] DATA_START_BYTE = 8'h81;
    localparam logic [7:0] PKT_END_BYTE = 8'h03;
    localparam logic [7:0] CMD_CODE = 8'h36;
    localparam logic [7:0] RESP_OK = 8'h36;
    localparam logic [7:0] RESP_ERR = 8'hB6;
    localparam logic [7:0] STATUS_LEN_HIGH = 8'h00;
    localparam logic [7:0] STATUS_LEN_LOW = 8'h0A;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_PACKET_ERR = 8'hC1;
    localparam logic [7:0] STS_CHECKSUM_ERR = 8'hC2;
    localparam logic [7:0] STS_ACCEPT_ERR = 8'hC3;
    localparam logic [7:0] STS_SECURE_ERR = 8'hC4;
    localparam logic [7:0] STS_PARAM_ERR = 8'hC5;
    localparam logic [7:0] STS_FLASH_INIT_ERR = 8'hC6;
    localparam logic [7:0] OCK_MAX = 8'h03;
    localparam logic [7:0] SUPPLY_MAX = 8'h01;
    localparam logic [15:0] CMD_LEN = 16'h0007;
    localparam logic [15:0] PKT_LEN_MIN = 16'h0001;
    localparam logic [15:0] PKT_LEN_MAX = 16'h0401;
    localparam logic [15:0] DATA_LEN_MIN = 16'h0005;
    localparam logic [31:0] DRV_LEN_MAX = 32'h0003_7000;
    localparam logic [31:0] INIT_OK = 32'h0000_0000;
    localparam logic [31:0] INIT_FAIL = 32'hFFFF_FFFF;
    localparam logic [3:0] STATUS_LAST_IDX = 4'hE;
    localparam int DRV_AW = 16;
    localparam int DRV_WORDS = 56320;
    localparam logic [15:0] DRV_BASE_WORD = 16'h0000;

    typedef enum logic [3:0] {
        ST_HUNT = 4'b0000,
        ST_LEN_HIGH = 4'b0001,
        ST_LEN_LOW = 4'b0010,
        ST_BODY = 4'b0011,
        ST_SUM = 4'b0100,
        ST_END = 4'b0101,
        ST_EVAL = 4'b0110,
        ST_SEND = 4'b0111,
        ST_INIT_WAIT = 4'b1000
    } state_e;
endpackage : ext_flash_setup_pkg

// ==== drv_ram.sv ====
// Driver code memory, one write port and one registered read port
`timescale 1ns/1ps
module drv_ram
    import ext_flash_setup_pkg::*;
(
    input wire logic mclk_i,
    input wire logic wr_en_i,
    input wire logic [DRV_AW-1:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [DRV_AW-1:0] rd_addr_i,
    output logic [31:0] rd_data_o
);
    logic [31:0] mem [0:DRV_WORDS-1];

    always_ff @(posedge mclk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : drv_ram

// ==== ext_flash_setup_monitor.sv ====
// Port checks for the external flash setup command handler
`timescale 1ns/1ps
module ext_flash_setup_monitor
    import ext_flash_setup_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic flash_if_setup_o,
    input wire logic [7:0] octal_clock_code_o,
    input wire logic [7:0] supply_code_o,
    input wire logic [31:0] driver_length_o,
    input wire logic init_req_o
);
    logic [3:0] idx_r, idx_nxt;
    logic [7:0] sum_r, sum_nxt;
    logic [7:0] res_r, res_nxt;
    logic hs;
    assign hs = tx_valid_o && tx_ready_i;
    always_comb begin
        idx_nxt = idx_r;
        sum_nxt = sum_r;
        res_nxt = res_r;
        if (hs) begin
            idx_nxt = (idx_r == STATUS_LAST_IDX) ? 4'h0 : idx_r + 4'h1;
            sum_nxt = (idx_r == 4'h0) ? 8'h00 : sum_r + tx_data_o;
            if (idx_r == 4'h3) begin
                res_nxt = tx_data_o;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            idx_r <= 4'h0;
            sum_r <= 8'h00;
            res_r <= 8'h00;
        end else begin
            idx_r <= idx_nxt;
            sum_r <= sum_nxt;
            res_r <= res_nxt;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take(logic [3:0] n);
        hs && idx_r == n;
    endsequence
    sequence s_quiet;
        !init_req_o && !tx_valid_o;
    endsequence
    chk_status_start: assert property (
        $rose(tx_valid_o) |-> tx_data_o == DATA_START_BYTE && idx_r == 4'h0)
        else $error("status packet does not open with start byte");
    chk_len_low: assert property (s_take(4'h2) |->
        tx_data_o == STATUS_LEN_LOW)
        else $error("status length byte wrong");
    chk_fill_bytes: assert property (
        hs && idx_r >= 4'h5 && idx_r <= 4'hC |-> tx_data_o == FILL_BYTE)
        else $error("status details or address not filled");
    chk_res_pair: assert property (s_take(4'h4) |->
        (res_r == RESP_OK) ? tx_data_o == STS_OK
        : (res_r == RESP_ERR && tx_data_o != STS_OK))
        else $error("response and status code disagree");
    chk_end_sum: assert property (s_take(4'hE) |->
        tx_data_o == PKT_END_BYTE && sum_r == 8'h00 ##1 !tx_valid_o)
        else $error("status checksum or end byte wrong");
    chk_setup_ok: assert property (flash_if_setup_o |->
        ##[0:1] (tx_valid_o && tx_data_o == DATA_START_BYTE))
        else $error("setup pulse without status packet");
    chk_codes_valid: assert property (flash_if_setup_o |->
        ##1 (octal_clock_code_o <= OCK_MAX && supply_code_o <= SUPPLY_MAX
        && driver_length_o != 32'h0 && driver_length_o <= DRV_LEN_MAX))
        else $error("command accepted with bad parameters");
    chk_init_quiet: assert property (
        init_req_o |-> !tx_valid_o ##1 s_quiet)
        else $error("status sent around initialization call");
    chk_tx_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("status byte changed before taken");
    chk_reset_idle: assert property ($rose(rstn_i) |->
        !tx_valid_o && !init_req_o && octal_clock_code_o == 8'h00)
        else $error("outputs not idle after reset");
endmodule : ext_flash_setup_monitor

bind ext_flash_setup_cmd_handler ext_flash_setup_monitor i_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .flash_if_setup_o(flash_if_setup_o),
    .octal_clock_code_o(octal_clock_code_o),
    .supply_code_o(supply_code_o), .driver_length_o(driver_length_o),
    .init_req_o(init_req_o));

// ==== host_tool_model.sv ====
// Host tool model: sends packets byte by byte and takes status packets
`timescale 1ns/1ps
module host_tool_model (
    input wire logic mclk_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic [7:0] byte_o,
    output logic byte_valid_o,
    output logic ready_o
);
    initial begin
        byte_o = 8'h00;
        byte_valid_o = 1'b0;
        ready_o = 1'b0;
    end
    task put_byte(input logic [7:0] x);
        @(posedge mclk_i);
        byte_o <= x;
        byte_valid_o <= 1'b1;
        @(posedge mclk_i);
        byte_valid_o <= 1'b0;
        byte_o <= ~x;
    endtask : put_byte
    task send_pkt(input logic [7:0] st, input logic [15:0] ln,
                  input logic [7:0] b[$], input logic [7:0] sx,
                  input logic [7:0] eb);
        logic [7:0] s;
        s = ln[15:8] + ln[7:0];
        foreach (b[i]) s = s + b[i];
        put_byte(st);
        put_byte(ln[15:8]);
        put_byte(ln[7:0]);
        foreach (b[i]) put_byte(b[i]);
        put_byte((8'h00 - s) ^ sx);
        put_byte(eb);
    endtask : send_pkt
    task get_status(input bit slow, output logic [7:0] p[15],
                    output bit to);
        bit got;
        to = 1'b0;
        @(posedge mclk_i);
        ready_o <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            got = 1'b0;
            for (int k = 0; k < 300 && !got; k++) begin
                @(negedge mclk_i);
                got = (tx_valid_i === 1'b1) && ready_o;
            end
            to = to | !got;
            p[i] = tx_data_i;
            @(posedge mclk_i);
            if (slow || i == 14) begin
                ready_o <= 1'b0;
            end
            if (slow && i < 14) begin
                repeat (2) @(posedge mclk_i);
                ready_o <= 1'b1;
            end
        end
    endtask : get_status
endmodule : host_tool_model

// ==== tb_ext_flash_setup_cmd_handler.sv ====
// Self-checking testbench of the external flash setup command handler
`timescale 1ns/1ps
module tb_ext_flash_setup_cmd_handler
    import ext_flash_setup_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] rx_data, tx_data, octal_clock_code, vcc;
    logic rx_valid, tx_valid, tx_ready, setup, init_req;
    logic lc = 1'b1;
    logic rs = 1'b1;
    logic au = 1'b0;
    logic init_done = 1'b0;
    logic [31:0] init_res = 32'h0;
    logic [31:0] dlen, rd_data;
    logic [DRV_AW-1:0] rd_addr = '0;
    int mismatches = 0;
    int total_checks = 0;
    always #20 mclk_i = ~mclk_i;
    ext_flash_setup_cmd_handler i_ext_flash_setup_cmd_handler (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .lifecycle_allows_i(lc),
        .reset_since_enc_write_i(rs), .auth_lowest_i(au),
        .flash_if_setup_o(setup), .octal_clock_code_o(octal_clock_code),
        .supply_code_o(vcc), .driver_length_o(dlen), .init_req_o(init_req),
        .init_done_i(init_done), .init_result_i(init_res),
        .drv_rd_addr_i(rd_addr), .drv_rd_data_o(rd_data));
    host_tool_model i_host_tool_model (
        .mclk_i(mclk_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .byte_o(rx_data), .byte_valid_o(rx_valid), .ready_o(tx_ready));
    task final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task expect_status(input logic [7:0] r, s, input bit slow);
        logic [7:0] p[15];
        logic [7:0] e;
        bit to;
        i_host_tool_model.get_status(slow, p, to);
        if (to) begin
            mismatches++;
            final_report();
        end
        for (int i = 0; i < 15; i++) begin
            case (i)
                0: e = DATA_START_BYTE;
                1: e = STATUS_LEN_HIGH;
                2: e = STATUS_LEN_LOW;
                3: e = r;
                4: e = s;
                13: e = 8'h00 - (STATUS_LEN_LOW + r + s + 8'hF8);
                14: e = PKT_END_BYTE;
                default: e = FILL_BYTE;
            endcase
            check("status byte", p[i], e);
        end
    endtask : expect_status
    task cmd(input logic [7:0] k, v, input logic [31:0] n,
             input logic [2:0] acc, input logic [7:0] sx, eb,
             input logic [15:0] ln, input logic [7:0] r, s);
        logic [7:0] b[$];
        b = '{CMD_CODE, k, v, n[31:24], n[23:16], n[15:8], n[7:0]};
        b = b[0:ln-1];
        @(posedge mclk_i);
        lc <= acc[2];
        rs <= acc[1];
        au <= acc[0];
        i_host_tool_model.send_pkt(CMD_START_BYTE, ln, b, sx, eb);
        expect_status(r, s, 1'b0);
    endtask : cmd
    task dat(input logic [7:0] rc, input int n, input logic [7:0] b0,
             input logic [7:0] sx, eb);
        logic [7:0] b[$];
        b = '{rc};
        for (int i = 0; i < n; i++) b.push_back(b0 + 8'(i));
        i_host_tool_model.send_pkt(DATA_START_BYTE, 16'(n + 1), b, sx, eb);
    endtask : dat
    task run_init(input logic [31:0] r);
        bit got;
        got = 1'b0;
        for (int k = 0; k < 300 && !got; k++) begin
            @(negedge mclk_i);
            got = (init_req === 1'b1);
        end
        if (!got) begin
            mismatches++;
            final_report();
        end
        check("status during init", tx_valid, 1'b0);
        @(posedge mclk_i);
        init_done <= 1'b1;
        init_res <= r;
        @(posedge mclk_i);
        init_done <= 1'b0;
    endtask : run_init
    task t_noise_ok();
        i_host_tool_model.put_byte(DATA_START_BYTE);
        i_host_tool_model.put_byte(CMD_CODE);
        cmd(8'h03, 8'h01, 32'h8, 3'b110, 8'h0, 8'h03, 7, RESP_OK, STS_OK);
        check("clock code", octal_clock_code, 8'h03);
        check("supply code", vcc, 8'h01);
        check("driver length", dlen, 32'h8);
        i_host_tool_model.put_byte(CMD_START_BYTE);
        dat(RESP_OK, 4, 8'h11, 8'h0, PKT_END_BYTE);
        expect_status(RESP_OK, STS_OK, 1'b1);
        dat(RESP_OK, 4, 8'h15, 8'h0, PKT_END_BYTE);
        run_init(INIT_OK);
        expect_status(RESP_OK, STS_OK, 1'b0);
        for (int w = 0; w < 2; w++) begin
            @(posedge mclk_i);
            rd_addr <= DRV_AW'(w);
            @(posedge mclk_i);
            @(negedge mclk_i);
            check("ram word", rd_data, 32'h14131211 + w * 32'h04040404);
        end
    endtask : t_noise_ok
    task t_cmd_errs();
        cmd(0, 0, 8, 3'b110, 1, 0, 7, RESP_ERR, STS_PACKET_ERR);
        cmd(0, 0, 8, 3'b110, 1, 3, 7, RESP_ERR, STS_CHECKSUM_ERR);
        cmd(0, 0, 8, 3'b110, 0, 3, 6, RESP_ERR, STS_PACKET_ERR);
        cmd(0, 0, 8, 3'b011, 0, 3, 7, RESP_ERR, STS_ACCEPT_ERR);
        cmd(0, 0, 8, 3'b100, 0, 3, 7, RESP_ERR, STS_ACCEPT_ERR);
        cmd(0, 0, 8, 3'b111, 0, 3, 7, RESP_ERR, STS_SECURE_ERR);
        cmd(4, 0, 8, 3'b110, 0, 3, 7, RESP_ERR, STS_PARAM_ERR);
        cmd(0, 2, 8, 3'b110, 0, 3, 7, RESP_ERR, STS_PARAM_ERR);
        cmd(0, 0, 0, 3'b110, 0, 3, 7, RESP_ERR, STS_PARAM_ERR);
        cmd(0, 0, 32'h37001, 3'b110, 0, 3, 7, RESP_ERR, STS_PARAM_ERR);
        cmd(0, 0, 32'h37000, 3'b110, 0, 3, 7, RESP_OK, STS_OK);
        dat(8'h37, 4, 8'h21, 8'h0, PKT_END_BYTE);
        expect_status(RESP_ERR, STS_PACKET_ERR, 1'b0);
    endtask : t_cmd_errs
    task t_data_errs();
        cmd(1, 0, 8, 3'b110, 0, 3, 7, RESP_OK, STS_OK);
        dat(RESP_OK, 4, 8'h31, 8'h01, PKT_END_BYTE);
        expect_status(RESP_ERR, STS_CHECKSUM_ERR, 1'b0);
        cmd(2, 0, 8, 3'b110, 0, 3, 7, RESP_OK, STS_OK);
        dat(RESP_OK, 12, 8'h41, 8'h0, PKT_END_BYTE);
        expect_status(RESP_ERR, STS_PARAM_ERR, 1'b0);
        cmd(0, 1, 8, 3'b110, 0, 3, 7, RESP_OK, STS_OK);
        dat(RESP_OK, 4, 8'h51, 8'h0, 8'h00);
        expect_status(RESP_ERR, STS_PACKET_ERR, 1'b0);
        cmd(0, 0, 4, 3'b110, 0, 3, 7, RESP_OK, STS_OK);
        dat(RESP_OK, 4, 8'h61, 8'h0, PKT_END_BYTE);
        run_init(INIT_FAIL);
        expect_status(RESP_ERR, STS_FLASH_INIT_ERR, 1'b1);
    endtask : t_data_errs
    initial begin
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_noise_ok();
        t_cmd_errs();
        t_data_errs();
        final_report();
    end
endmodule : tb_ext_flash_setup_cmd_handler
